// >>> shared/smhc_pkg.sv
// Package for the step mode halt control: register map, fields, codes and helpers
package smhc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] SMHC_OFF_CTRL = 5'h00;
  localparam logic [4:0] SMHC_OFF_STATIC = 5'h04;
  localparam logic [4:0] SMHC_OFF_CTLREG = 5'h08;
  localparam logic [4:0] SMHC_OFF_STATUS = 5'h0c;
  localparam logic [4:0] SMHC_OFF_LAMPS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SMHC_CTRL_SEL_LSB = 0;
  localparam int SMHC_CTRL_START_BIT = 8;
  localparam int SMHC_CTRL_STOP_BIT = 9;
  localparam int SMHC_CTRL_RUNCR_BIT = 10;
  localparam int SMHC_ST_STOPPED_BIT = 0;
  localparam int SMHC_ST_STALL_BIT = 1;
  localparam int SMHC_ST_CYC_LSB = 2;
  localparam int SMHC_ST_SEQ_LSB = 4;
  localparam int SMHC_ST_PASS_LSB = 8;
  localparam int SMHC_ST_AUTO_BIT = 11;
  localparam int SMHC_ST_MODE_LSB = 12;
  localparam int SMHC_ST_ARMED_BIT = 15;

  // ----------------------------------------------------------------
  // Selector positions and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SMHC_SEL_NORMAL = 3'h0;
  localparam logic [2:0] SMHC_SEL_ONE_INSTR = 3'h1;
  localparam logic [2:0] SMHC_SEL_ONE_OPER = 3'h2;
  localparam logic [2:0] SMHC_SEL_ONE_STEP = 3'h3;
  localparam logic [2:0] SMHC_SEL_ONE_ADD = 3'h4;
  localparam logic [2:0] SMHC_SEL_RESET = 3'h2;
  localparam logic [19:0] SMHC_INSTR_RESET = 20'h00000;

  // Index of the last pass; block transfers run six passes of ten words
  localparam logic [2:0] SMHC_LAST_PASS = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_ONE_INSTR, MODE_ONE_OPER, MODE_ONE_STEP, MODE_ONE_ADD
  } smhc_mode_t;

  typedef enum logic [1:0] {
    EV_CYCLE, EV_INTER, EV_SEQ_STOP, EV_ADD
  } smhc_ev_t;

  typedef enum logic [1:0] {
    AB_IDLE, AB_EXEC, AB_WAIT
  } smhc_ab_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Selector field to mode, unknown positions act as normal
  function automatic smhc_mode_t smhc_mode_of(input logic [2:0] sel);
    case (sel)
      SMHC_SEL_ONE_INSTR: smhc_mode_of = MODE_ONE_INSTR;
      SMHC_SEL_ONE_OPER: smhc_mode_of = MODE_ONE_OPER;
      SMHC_SEL_ONE_STEP: smhc_mode_of = MODE_ONE_STEP;
      SMHC_SEL_ONE_ADD: smhc_mode_of = MODE_ONE_ADD;
      default: smhc_mode_of = MODE_NORMAL;
    endcase
  endfunction

  // Read or write block transfer: first digit 3, 4, 5 or 7
  function automatic logic smhc_is_block(input logic [19:0] ins);
    smhc_is_block = (ins[3:0] == 4'h3) || (ins[3:0] == 4'h4) ||
                    (ins[3:0] == 4'h5) || (ins[3:0] == 4'h7);
  endfunction

  // Advance a decimal address by ten cells, digits d4,d5,d6 in [19:8]
  function automatic logic [19:0] smhc_add_ten(input logic [19:0] ins);
    logic [3:0] hund;
    logic [3:0] tens;
    hund = ins[11:8];
    tens = ins[15:12];
    if (tens == 4'h9) begin
      tens = 4'h0;
      hund = (hund == 4'h9) ? 4'h0 : hund + 4'h1;
    end else begin
      tens = tens + 4'h1;
    end
    smhc_add_ten = {ins[19:16], tens, hund, ins[7:0]};
  endfunction

endpackage

// >>> rtl/smhc_lamp_enc.sv
// Lamp encoder: decimal instruction digits to check-bit excess-three patterns
`timescale 1ns/1ps
module smhc_lamp_enc
  import smhc_pkg::*;
(
  // Decimal digits d1,d2,d4,d5,d6 as nibbles from low to high
  input wire logic [19:0] instr,
  // First digit in [26:20], then d2,d4,d5,d6 five bits each from [19:15] down
  output logic [26:0] lamps
);

  // ----------------------------------------------------------------
  // Five-bit pattern: odd check bit above the excess-three code
  // ----------------------------------------------------------------
  function automatic logic [4:0] xs3_five(input logic [3:0] dig);
    logic [3:0] x;
    x = dig + 4'h3;
    xs3_five = {~^x, x};
  endfunction

  // Digit codes
  wire logic [4:0] d1_five = xs3_five(instr[3:0]);
  wire logic [6:0] d1_code = {d1_five[4], 2'h0, d1_five[3:0]}; // RL19
  wire logic [4:0] d2_code = xs3_five(instr[7:4]); // RL18
  wire logic [4:0] d4_code = xs3_five(instr[11:8]); // RL18
  wire logic [4:0] d5_code = xs3_five(instr[15:12]); // RL18
  wire logic [4:0] d6_code = xs3_five(instr[19:16]); // RL18

  assign lamps = {d1_code, d2_code, d4_code, d5_code, d6_code};

endmodule // smhc_lamp_enc

// >>> rtl/smhc_core.sv
// Step mode halt control: selector, stop logic, start bar and block set-up
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// [RL1] Normal position runs continuously, never pausing at a time-out.
// [RL2] Normal position halts only on a decoded stop or breakpoint instruction; the code also halts on a stop command written to the control register.
// [RL3] Stopped means stop flip-flop set and lamp lit; error stall is separate.
// [RL4] One-instruction halts at alpha, beta, gamma and delta time-outs.
// [RL5] One-operation halts at every normal time-out, including between stages.
// [RL6] Single-stage instructions behave alike in one-instruction and one-operation.
// [RL7] Multi-stage instructions get a time-out between stages; sequencer tracks them.
// [RL8] One-step equals one-operation for multiply, divide and shift; the code halts only those at sequencer stops, the rest match one-operation.
// [RL9] One-step halts at every sequencer stop, forcing a time-out there; the code halts there only for multiply, divide and shift.
// [RL10] One-addition is one-step plus a halt after each mul/div addition.
// [RL11] While stopped, static register is loaded; start bar executes it.
// [RL12] Operator enters control-transfer instructions via the control register.
// [RL13] Manual sixty-word reads need one-operation mode and six set-ups.
// [RL14] Tape writes need the same six-fold manual set-up.
// [RL15] Each manual set-up keeps the opcode, address advances by ten.
// [RL16] Manual block transfer execution alters the control register contents.
// [RL17] Block transfer from control register sequences all six set-ups itself.
// [RL18] Digits two, four, five, six shown as check bit plus excess-three.
// [RL19] First digit shown as seven-bit code with check bit.
// [RL20] Operator leaves normal and lights stop lamps before manual work.
// [RL21] Selector sampled at each time-out boundary, effective at next halt.
// [RL22] Start resumes exactly at the halted stage, none repeated or skipped.
module smhc_core
  import smhc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Events from the cycling unit and decoder
  input wire logic ev_valid,
  input wire smhc_ev_t ev_kind,
  input wire logic instr_muldiv,
  input wire logic instr_shift,
  input wire logic decode_halt,
  input wire logic err_stall,
  input wire logic exec_done,
  // Machine control
  output logic run_en,
  output logic stop_lamp,
  output logic stall_lamp,
  output logic tout_force,
  output logic exec_req,
  output logic [19:0] exec_instr,
  output logic [1:0] cycle_stage
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] sel_q, sel_d;
  smhc_mode_t mode_q, mode_d;
  logic stop_q, stop_d;
  logic armed_q, armed_d;
  logic [19:0] static_q, static_d;
  logic [19:0] ctlreg_q, ctlreg_d;
  logic [1:0] cyc_q, cyc_d;
  logic [3:0] seq_q, seq_d;
  logic [2:0] pass_q, pass_d;
  smhc_ab_t ab_q, ab_d;
  logic exec_q, exec_d;
  logic tout_q, tout_d;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  logic [26:0] lamps;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic hit_ctrl = avs_address == SMHC_OFF_CTRL;
  wire logic hit_static = avs_address == SMHC_OFF_STATIC;
  wire logic hit_ctlreg = avs_address == SMHC_OFF_CTLREG;
  wire logic hit_status = avs_address == SMHC_OFF_STATUS;
  wire logic hit_lamps = avs_address == SMHC_OFF_LAMPS;
  wire logic wr_ctrl = avs_write & hit_ctrl;
  wire logic cmd_start = wr_ctrl & avs_writedata[SMHC_CTRL_START_BIT];
  wire logic cmd_stop = wr_ctrl & avs_writedata[SMHC_CTRL_STOP_BIT];
  wire logic cmd_runcr = wr_ctrl & avs_writedata[SMHC_CTRL_RUNCR_BIT];
  wire logic rd_first = avs_read & ~rd_ack_q;

  // Reads wait one cycle for registered data, writes are taken at once
  assign avs_waitrequest = rd_first;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Halt decision
  // ----------------------------------------------------------------
  // Selector is taken at time-out boundaries only
  wire logic at_tout = ev_valid & ((ev_kind == EV_CYCLE) | (ev_kind == EV_INTER)); // RL21
  wire smhc_mode_t eff_mode = at_tout ? smhc_mode_of(sel_q) : mode_q; // RL21
  wire logic is_cyc = ev_kind == EV_CYCLE;
  wire logic is_tout = (ev_kind == EV_CYCLE) | (ev_kind == EV_INTER);
  wire logic plain_ins = ~(instr_muldiv | instr_shift);
  // Sequencer stops halt only multiply, divide and shift; the rest act as one-operation
  wire logic step_hit = is_tout | ((ev_kind == EV_SEQ_STOP) & ~plain_ins); // RL8 RL9
  wire logic add_hit = (ev_kind == EV_ADD) & instr_muldiv; // RL10
  logic mode_hit;

  // Where each selector position stops the machine
  always_comb begin
    case (eff_mode)
      MODE_NORMAL: mode_hit = 1'b0; // RL1
      MODE_ONE_INSTR: mode_hit = is_cyc; // RL4 RL6
      MODE_ONE_OPER: mode_hit = is_tout; // RL5 RL6
      MODE_ONE_STEP: mode_hit = step_hit; // RL8 RL9
      MODE_ONE_ADD: mode_hit = step_hit | add_hit; // RL10
      default: mode_hit = 1'b0;
    endcase
  end

  // Events count only while the machine is actually moving
  wire logic running = ~stop_q & ~err_stall;
  wire logic ev_live = ev_valid & running;
  wire logic halt_now = (ev_live & mode_hit) | (running & decode_halt) | cmd_stop; // RL2 RL3
  wire logic start_ok = stop_q & cmd_start & (ab_q == AB_IDLE);
  wire logic runcr_ok = stop_q & cmd_runcr & (ab_q == AB_IDLE);
  wire logic blk_ctl = smhc_is_block(ctlreg_q);

  // Stall holds the machine without counting as stopped
  assign run_en = running; // RL3 RL22
  assign stop_lamp = stop_q; // RL3
  assign stall_lamp = err_stall & ~stop_q; // RL3
  assign tout_force = tout_q;
  assign exec_req = exec_q;
  assign exec_instr = static_q;
  assign cycle_stage = cyc_q;

  // ----------------------------------------------------------------
  // Stop flip-flop, start bar and selector
  // ----------------------------------------------------------------
  always_comb begin
    sel_d = sel_q;
    mode_d = eff_mode;
    stop_d = stop_q;
    tout_d = ev_live & mode_hit & (ev_kind == EV_SEQ_STOP); // RL9
    if (wr_ctrl) begin
      sel_d = avs_writedata[SMHC_CTRL_SEL_LSB +: 3];
    end
    // Resume leaves the datapath where it halted; no stage replayed
    if (start_ok | runcr_ok) begin
      stop_d = 1'b0; // RL22
    end
    // A halt in the same cycle as start wins
    if (halt_now) begin
      stop_d = 1'b1; // RL2 RL3
    end
  end

  // ----------------------------------------------------------------
  // Cycle stage and stage sequencer tracking
  // ----------------------------------------------------------------
  always_comb begin
    cyc_d = cyc_q;
    seq_d = seq_q;
    if (ev_live) begin
      case (ev_kind)
        EV_CYCLE: begin
          cyc_d = cyc_q + 2'h1; // RL4
          seq_d = 4'h0;
        end
        EV_INTER: seq_d = seq_q + 4'h1; // RL7
        EV_SEQ_STOP: seq_d = seq_q + 4'h1; // RL7 RL9
        default: seq_d = seq_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Static register, control register and block transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    static_d = static_q;
    ctlreg_d = ctlreg_q;
    armed_d = armed_q;
    pass_d = pass_q;
    ab_d = ab_q;
    exec_d = 1'b0;
    // Manual set-up only while stopped
    if (avs_write & hit_static & stop_q) begin
      static_d = avs_writedata[19:0]; // RL11
      armed_d = 1'b1;
    end
    if (avs_write & hit_ctlreg & stop_q & (ab_q == AB_IDLE)) begin
      ctlreg_d = avs_writedata[19:0]; // RL12
    end
    case (ab_q)
      AB_IDLE: begin
        if (start_ok & armed_q) begin
          exec_d = 1'b1; // RL11
          armed_d = 1'b0;
          if (smhc_is_block(static_q)) begin
            ctlreg_d = smhc_add_ten(static_q); // RL16
          end
        end else if (runcr_ok) begin
          static_d = ctlreg_q;
          exec_d = 1'b1;
          armed_d = 1'b0;
          pass_d = 3'h0;
          if (blk_ctl) begin
            ab_d = AB_WAIT; // RL17
          end
        end
      end
      AB_WAIT: begin
        if (exec_done) begin
          if (pass_q == SMHC_LAST_PASS) begin
            ab_d = AB_IDLE; // RL17
          end else begin
            pass_d = pass_q + 3'h1;
            static_d = smhc_add_ten(static_q); // RL15 RL17
            ab_d = AB_EXEC;
          end
        end
      end
      AB_EXEC: begin
        // Next pass waits while halted or stalled
        if (running) begin
          exec_d = 1'b1; // RL17
          ab_d = AB_WAIT;
        end
      end
      default: ab_d = AB_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [31:0] status_w = {16'h0000, armed_q, eff_mode, ab_q != AB_IDLE, pass_q,
                                seq_q, cyc_q, err_stall, stop_q};
  wire logic [31:0] rd_mux = hit_ctrl ? {29'h0000000, sel_q} :
                             hit_static ? {12'h000, static_q} :
                             hit_ctlreg ? {12'h000, ctlreg_q} :
                             hit_status ? status_w :
                             hit_lamps ? {5'h00, lamps} : 32'h00000000;

  // Lamp patterns of the static register
  smhc_lamp_enc u_lamp_enc (
    .instr(static_q),
    .lamps(lamps)
  ); // RL18 RL19

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      rd_ack_q <= rd_first;
      if (rd_first) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Control state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_q <= SMHC_SEL_RESET;
      mode_q <= MODE_ONE_OPER;
      stop_q <= 1'b1;
      tout_q <= 1'b0;
      cyc_q <= 2'h0;
      seq_q <= 4'h0;
    end else begin
      sel_q <= sel_d;
      mode_q <= mode_d;
      stop_q <= stop_d;
      tout_q <= tout_d;
      cyc_q <= cyc_d;
      seq_q <= seq_d;
    end
  end

  // Instruction registers and sequencing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      static_q <= SMHC_INSTR_RESET;
      ctlreg_q <= SMHC_INSTR_RESET;
      armed_q <= 1'b0;
      pass_q <= 3'h0;
      ab_q <= AB_IDLE;
      exec_q <= 1'b0;
    end else begin
      static_q <= static_d;
      ctlreg_q <= ctlreg_d;
      armed_q <= armed_d;
      pass_q <= pass_d;
      ab_q <= ab_d;
      exec_q <= exec_d;
    end
  end

endmodule // smhc_core

// >>> verification/smhc_core_props.sv
// Port assertions for the step mode halt control core
`timescale 1ns/1ps
module smhc_core_props
  import smhc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Machine events
  input wire logic ev_valid,
  input wire smhc_ev_t ev_kind,
  input wire logic instr_muldiv,
  input wire logic instr_shift,
  input wire logic decode_halt,
  input wire logic err_stall,
  input wire logic exec_done,
  // Machine control
  input wire logic run_en,
  input wire logic stop_lamp,
  input wire logic stall_lamp,
  input wire logic tout_force,
  input wire logic exec_req,
  input wire logic [19:0] exec_instr,
  input wire logic [1:0] cycle_stage
);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  AST_RD_ONEWAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
  AST_RUN_EN: assert property (run_en == (!stop_lamp && !err_stall))
    else $error("run enable wrong");
  AST_STALL_LAMP: assert property (stall_lamp == (err_stall && !stop_lamp))
    else $error("stall lamp wrong");
  AST_DECODE_HALT: assert property (run_en && decode_halt |=> stop_lamp)
    else $error("decoded stop ignored");
  AST_NO_SPUR_HALT: assert property ($rose(stop_lamp) |-> $past(ev_valid || decode_halt || avs_write))
    else $error("halt without cause");
  AST_TOUT_CAUSE: assert property (tout_force |-> stop_lamp && $past(ev_valid && run_en && ev_kind == EV_SEQ_STOP))
    else $error("forced time-out without sequencer stop");
  AST_STAGE_ADV: assert property (run_en && ev_valid && ev_kind == EV_CYCLE |=> cycle_stage == $past(cycle_stage) + 2'h1)
    else $error("cycle stage did not advance by one");
  AST_STAGE_HOLD: assert property (!run_en |=> $stable(cycle_stage))
    else $error("cycle stage moved while stopped");
  AST_EXEC_PULSE: assert property (exec_req |=> !exec_req)
    else $error("execute request longer than one cycle");
endmodule // smhc_core_props

bind smhc_core smhc_core_props i_smhc_core_props (.mclk(mclk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ev_valid(ev_valid), .ev_kind(ev_kind),
  .instr_muldiv(instr_muldiv), .instr_shift(instr_shift), .decode_halt(decode_halt),
  .err_stall(err_stall), .exec_done(exec_done), .run_en(run_en), .stop_lamp(stop_lamp),
  .stall_lamp(stall_lamp), .tout_force(tout_force), .exec_req(exec_req),
  .exec_instr(exec_instr), .cycle_stage(cycle_stage));

// >>> verification/smhc_dp_model.sv
// Datapath stand-in that answers execute requests after a delay
`timescale 1ns/1ps
module smhc_dp_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Execute handshake
  input wire logic exec_req,
  output logic exec_done
);
  int cnt_q;
  // Count down from a request, pulse done when it runs out
  always_ff @(posedge mclk) begin
    exec_done <= rst_n && (cnt_q == 1);
    if (!rst_n) cnt_q <= 0;
    else if (exec_req) cnt_q <= DLY;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
endmodule // smhc_dp_model

// >>> verification/tb_top.sv
// Self-checking testbench for the step mode halt control core
`timescale 1ns/1ps
module tb_top;
  import smhc_pkg::*;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, ev_valid, instr_muldiv;
  logic instr_shift, decode_halt, err_stall, exec_done, run_en, stop_lamp, stall_lamp;
  logic tout_force, exec_req;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [19:0] exec_instr;
  logic [1:0] cycle_stage;
  smhc_ev_t ev_kind;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [6:0] l7 [10] = '{7'h43, 7'h04, 7'h45, 7'h46, 7'h07, 7'h08, 7'h49, 7'h4a, 7'h0b, 7'h4c};
  logic [4:0] l5 [10] = '{5'h13, 5'h04, 5'h15, 5'h16, 5'h07, 5'h08, 5'h19, 5'h1a, 5'h0b, 5'h1c};

  // ------------------------------------------------
  // Instances
  // ------------------------------------------------
  smhc_core i_smhc_core (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev_valid(ev_valid),
    .ev_kind(ev_kind), .instr_muldiv(instr_muldiv), .instr_shift(instr_shift),
    .decode_halt(decode_halt), .err_stall(err_stall), .exec_done(exec_done),
    .run_en(run_en), .stop_lamp(stop_lamp), .stall_lamp(stall_lamp),
    .tout_force(tout_force), .exec_req(exec_req), .exec_instr(exec_instr),
    .cycle_stage(cycle_stage));
  smhc_dp_model #(.DLY(3)) i_smhc_dp_model (.mclk(mclk), .rst_n(rst_n),
    .exec_req(exec_req), .exec_done(exec_done));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write, held until waitrequest is seen low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // Bus read, data taken at the edge that sees waitrequest low
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // One-cycle cycling unit event
  task automatic ev(input smhc_ev_t k);
    ev_kind <= k;
    ev_valid <= 1'b1;
    @(posedge mclk);
    ev_valid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_exec();
    for (int n = 0; n < 50 && exec_req !== 1'b1; n++) @(posedge mclk);
    check(32'(exec_req), 32'h1);
  endtask
  // Expected lamp pattern from the digit code tables
  function automatic logic [31:0] lamp_of(input logic [19:0] s);
    return {5'h0, l7[s[3:0]], l5[s[7:4]], l5[s[11:8]], l5[s[15:12]], l5[s[19:16]]};
  endfunction

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    check({30'h0, run_en, stop_lamp}, 32'h1);
    check(32'(cycle_stage), 32'h0);
    rd(SMHC_OFF_STATUS, d);
    check(d, 32'h2001);
    wr(5'h14, 32'hffffffff);
    rd(5'h14, d);
    check(d, 32'h0);
    wr(SMHC_OFF_CTRL, 32'h4);
    rd(SMHC_OFF_STATUS, d);
    check(32'(d[14:12]), 32'h2);
    ev(EV_INTER);
    rd(SMHC_OFF_STATUS, d);
    check(32'(d[14:12]), 32'h4);
  endtask
  // Every selector position against every event kind
  task automatic t_modes();
    logic h;
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 4; k++) begin
        for (int s = 0; s < 2; s++) begin
          wr(SMHC_OFF_CTRL, 32'(m));
          ev(EV_CYCLE);
          wr(SMHC_OFF_CTRL, 32'h100 | 32'(m));
          instr_muldiv <= s[0];
          instr_shift <= s[0];
          ev(smhc_ev_t'(k));
          h = (k == 0 && m != 0) || (k == 1 && m >= 2) || (k == 2 && m >= 3 && s == 1);
          h = h || (k == 3 && m == 4 && s == 1);
          check(32'(stop_lamp), 32'(h));
          check(32'(tout_force), 32'(h && k == 2));
          if (!h) wr(SMHC_OFF_CTRL, 32'h200 | 32'(m));
        end
      end
    end
  endtask
  task automatic t_stall();
    logic [31:0] d;
    wr(SMHC_OFF_CTRL, 32'h100);
    err_stall <= 1'b1;
    repeat (2) @(posedge mclk);
    check({29'h0, stall_lamp, stop_lamp, run_en}, 32'h4);
    rd(SMHC_OFF_STATUS, d);
    check(32'(d[1:0]), 32'h2);
    err_stall <= 1'b0;
    @(posedge mclk);
    decode_halt <= 1'b1;
    @(posedge mclk);
    decode_halt <= 1'b0;
    @(posedge mclk);
    check(32'(stop_lamp), 32'h1);
  endtask
  // Six manual set-ups of a tape write, address up by ten each time
  task automatic t_manual();
    logic [31:0] d;
    logic [19:0] s;
    wr(SMHC_OFF_CTRL, 32'h202);
    ev(EV_CYCLE);
    wr(SMHC_OFF_STATIC, 32'h91019);
    rd(SMHC_OFF_LAMPS, d);
    check(d, lamp_of(20'h91019));
    for (int i = 0; i < 6; i++) begin
      s = {4'h0, 4'(4 + i), 12'h927};
      wr(SMHC_OFF_STATIC, 32'(s));
      rd(SMHC_OFF_LAMPS, d);
      check(d, lamp_of(s));
      wr(SMHC_OFF_CTRL, 32'h102);
      wait_exec();
      check(32'(exec_instr), 32'(s));
      repeat (6) @(posedge mclk);
      wr(SMHC_OFF_CTRL, 32'h202);
      rd(SMHC_OFF_CTLREG, d);
      check(d, (i < 5) ? 32'(s) + 32'h1000 : 32'h27);
    end
  endtask
  // Block transfer from the control register runs all six passes
  task automatic t_run_cr();
    logic [31:0] d;
    int n;
    n = 0;
    wr(SMHC_OFF_CTLREG, 32'h04927);
    wr(SMHC_OFF_CTRL, 32'h402);
    // First pulse already stands when the write returns, so look before each edge
    for (int c = 0; c < 200; c++) begin
      if (exec_req === 1'b1) begin
        check(32'(exec_instr), {12'h0, 4'h0, 4'(4 + n), 12'h927});
        n++;
      end
      @(posedge mclk);
    end
    check(32'(n), 32'h6);
    rd(SMHC_OFF_STATUS, d);
    check(32'(d[11]), 32'h0);
  endtask

  // ------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ev_valid = 1'b0;
    ev_kind = EV_CYCLE;
    instr_muldiv = 1'b0;
    instr_shift = 1'b0;
    decode_halt = 1'b0;
    err_stall = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_modes();
    t_stall();
    t_manual();
    t_run_cr();
    summarize();
  end
endmodule // tb_top
